// file: hdl/move_or_increment_regs.vh
// constants for the move / or / increment instruction group
`ifndef MOVE_OR_INCREMENT_REGS_VH
`define MOVE_OR_INCREMENT_REGS_VH

// opcode prefixes (upper bits of first or second word)
`define OP6_INC_SKIP_ZERO 6'b0011_11
`define OP6_INC_SKIP_NONZERO 6'b0100_10
`define OP6_OR_FILE 6'b0001_00
`define OP6_MOVE_FILE 6'b0101_00
`define OP7_STORE_WORKING 7'b0110_111
`define OP8_OR_LITERAL 8'b0000_1001
`define OP8_LOAD_BANK 8'b0000_0001
`define OP8_LOAD_LITERAL 8'b0000_1110
`define OP8_POINTER_LOAD 8'b1110_1110
`define OP4_FILE_MOVE_FIRST 4'b1100
`define OP4_SECOND_WORD 4'b1111
`define OP6_POINTER_SECOND 6'b1111_00

// field positions
`define BIT_DEST 9
`define BIT_ACCESS 8
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h80

// reset values
`define RESET_WORKING 8'h00
`define RESET_BANK 4'h0
`define RESET_IDLE_WORD 16'h0000

// phase count per instruction cycle
`define PHASES_PER_CYCLE 4

`endif

// file: hdl/phase_counter.v
// four-phase instruction clock generator
`timescale 1ns/1ns
module phase_counter (
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // phase outputs
    output reg [1:0] phase_o,
    output reg last_phase_o
);
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_o <= 2'h0;
            last_phase_o <= 1'b0;
        end else begin
            phase_o <= phase_o + 2'h1;
            last_phase_o <= (phase_o == 2'h2);
        end
    end
endmodule // phase_counter

// file: hdl/move_or_increment_core.v
// execution core for the move, or and increment-skip instruction group
//
// How it works
// - destination bit 0 to working, 1 to file
// - access bit selects access bank or bank selector
// - extended set, offset up to 95 is indexed
// - increment, skip next when result zero
// - increment, skip next when result nonzero
// - taken skip adds one idle cycle, two when the skipped word is a two-word instruction
// - or literal into working, sets N Z
// - or with file to destination, sets N Z
// - pointer load, two words, high then low
// - move file to destination, sets N Z
// - file-to-file move uses full 12-bit addresses
// - source read in second phase, destination write last phase
// - bank load keeps low nibble, upper zero
// - literal load into working, flags untouched
// - store working into file, flags untouched
`timescale 1ns/1ns
`include "move_or_increment_regs.vh"
module move_or_increment_core #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // mode
    input wire extended_set_i,
    // program fetch: word held for the whole instruction cycle
    input wire [15:0] instr_word_i,
    // data memory
    input wire [7:0] data_rd_i,
    output reg [ADDR_W-1:0] data_addr_o,
    output reg data_rd_o,
    output reg data_wr_o,
    output reg [7:0] data_wr_o_data,
    // state
    output reg [7:0] working_o,
    output reg [7:0] bank_selector_register_o,
    output reg flag_n_o,
    output reg flag_z_o,
    output reg [1:0] pointer_sel_o,
    output reg [11:0] data_pointer_o,
    output reg data_pointer_high_wr_o,
    output reg data_pointer_low_wr_o,
    output reg [8:0] pointer_index_o,
    output reg skip_o,
    output reg [1:0] phase_o,
    output reg advance_o
);
    // ------------------------------------------------------------
    // reset release and phases
    // ------------------------------------------------------------
    reg [1:0] rst_sync_reg;
    wire rst_n;
    wire [1:0] phase;
    wire last_phase;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    phase_counter u_phase (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .phase_o(phase),
        .last_phase_o(last_phase)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    localparam ST_FIRST = 2'h0;
    localparam ST_SECOND = 2'h1;
    localparam ST_SKIP = 2'h2;
    localparam ST_SKIP2 = 2'h3;

    localparam K_NONE = 4'h0;
    localparam K_INCZ = 4'h1;
    localparam K_INCNZ = 4'h2;
    localparam K_ORL = 4'h3;
    localparam K_ORF = 4'h4;
    localparam K_MOVE_FILE_OP = 4'h5;
    localparam K_STORE_WORKING_OP = 4'h6;
    localparam K_LOAD_LITERAL_OP = 4'h7;
    localparam K_LOAD_BANK_OP = 4'h8;
    localparam K_POINTER_LOAD_OP = 4'h9;
    localparam K_FILE_TO_FILE_MOVE_OP = 4'hA;

    function [3:0] classify;
        input [15:0] w;
        begin
            if (w[15:10] == `OP6_INC_SKIP_ZERO) classify = K_INCZ;
            else if (w[15:10] == `OP6_INC_SKIP_NONZERO) classify = K_INCNZ;
            else if (w[15:10] == `OP6_OR_FILE) classify = K_ORF;
            else if (w[15:10] == `OP6_MOVE_FILE) classify = K_MOVE_FILE_OP;
            else if (w[15:9] == `OP7_STORE_WORKING) classify = K_STORE_WORKING_OP;
            else if (w[15:8] == `OP8_OR_LITERAL) classify = K_ORL;
            else if (w[15:8] == `OP8_LOAD_LITERAL) classify = K_LOAD_LITERAL_OP;
            else if (w[15:8] == `OP8_LOAD_BANK) classify = K_LOAD_BANK_OP;
            else if (w[15:8] == `OP8_POINTER_LOAD && w[5:4] != 2'b11) classify = K_POINTER_LOAD_OP;
            else if (w[15:12] == `OP4_FILE_MOVE_FIRST) classify = K_FILE_TO_FILE_MOVE_OP;
            else classify = K_NONE;
        end
    endfunction

    // two-word instructions of the whole set, for skip cost
    function two_word;
        input [15:0] w;
        begin
            two_word = (w[15:12] == `OP4_FILE_MOVE_FIRST) ||
                (w[15:9] == 7'b1110_111) || (w[15:8] == 8'b1110_1100) ||
                (w[15:8] == 8'b1110_1101);
        end
    endfunction

    // banked address of an 8-bit operand
    function [ADDR_W-1:0] file_addr;
        input [15:0] w;
        input [7:0] bank;
        begin
            if (w[`BIT_ACCESS]) begin
                file_addr = {bank[3:0], w[7:0]};
            end else if (w[7:0] < `ACCESS_SPLIT) begin
                file_addr = {4'h0, w[7:0]};
            end else begin
                file_addr = {4'hF, w[7:0]};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    reg [1:0] state_reg;
    reg [15:0] first_reg;
    reg [3:0] kind_reg;
    reg [7:0] result_reg;
    wire [3:0] kind_now;
    wire indexed;
    wire file_op;
    assign kind_now = classify(instr_word_i);
    // literal and pointer forms never index, only file operands do
    assign file_op = (kind_now == K_INCZ) || (kind_now == K_INCNZ) || (kind_now == K_ORF) ||
        (kind_now == K_MOVE_FILE_OP) || (kind_now == K_STORE_WORKING_OP);
    // indexed literal offset is resolved outside; index reported here
    assign indexed = file_op && extended_set_i && !instr_word_i[`BIT_ACCESS] &&
        (instr_word_i[7:0] <= `INDEXED_LIMIT);

    always @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_FIRST;
            first_reg <= `RESET_IDLE_WORD;
            kind_reg <= K_NONE;
            result_reg <= 8'h00;
            working_o <= `RESET_WORKING;
            bank_selector_register_o <= {4'h0, `RESET_BANK};
            flag_n_o <= 1'b0;
            flag_z_o <= 1'b0;
            pointer_sel_o <= 2'h0;
            data_pointer_o <= 12'h000;
            data_pointer_high_wr_o <= 1'b0;
            data_pointer_low_wr_o <= 1'b0;
            pointer_index_o <= 9'h000;
            data_addr_o <= {ADDR_W{1'b0}};
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
            data_wr_o_data <= 8'h00;
            skip_o <= 1'b0;
            phase_o <= 2'h0;
            advance_o <= 1'b0;
        end else begin
            phase_o <= phase;
            data_rd_o <= 1'b0;
            data_wr_o <= 1'b0;
            data_pointer_high_wr_o <= 1'b0;
            data_pointer_low_wr_o <= 1'b0;
            advance_o <= last_phase;
            case (phase)
            2'h0: begin // decode
                if (state_reg == ST_FIRST) begin
                    first_reg <= instr_word_i;
                    kind_reg <= kind_now;
                    skip_o <= 1'b0;
                    pointer_index_o <= indexed ? {1'b1, instr_word_i[7:0]} : 9'h000;
                    data_addr_o <= file_addr(instr_word_i, bank_selector_register_o);
                    if (kind_now == K_FILE_TO_FILE_MOVE_OP) begin
                        data_addr_o <= instr_word_i[11:0];
                    end
                end
            end
            2'h1: begin // operand read
                if (state_reg == ST_FIRST) begin
                    case (kind_reg)
                    K_INCZ, K_INCNZ, K_ORF, K_MOVE_FILE_OP, K_STORE_WORKING_OP, K_FILE_TO_FILE_MOVE_OP: data_rd_o <= 1'b1;
                    default: data_rd_o <= 1'b0;
                    endcase
                end else if (state_reg == ST_SECOND && kind_reg == K_FILE_TO_FILE_MOVE_OP) begin
                    data_rd_o <= 1'b1; // dummy read
                    data_addr_o <= instr_word_i[11:0];
                end
            end
            2'h2: begin // process
                if (state_reg == ST_FIRST) begin
                    case (kind_reg)
                    K_INCZ, K_INCNZ: result_reg <= data_rd_i + 8'h01;
                    K_ORF: result_reg <= working_o | data_rd_i;
                    K_ORL: result_reg <= working_o | first_reg[7:0];
                    K_MOVE_FILE_OP, K_FILE_TO_FILE_MOVE_OP: result_reg <= data_rd_i;
                    K_STORE_WORKING_OP: result_reg <= working_o;
                    default: result_reg <= first_reg[7:0];
                    endcase
                end
            end
            default: begin // write
                if (state_reg == ST_FIRST) begin
                    case (kind_reg)
                    K_INCZ, K_INCNZ, K_ORF, K_MOVE_FILE_OP: begin
                        if (first_reg[`BIT_DEST]) begin
                            data_wr_o <= 1'b1;
                            data_wr_o_data <= result_reg;
                        end else begin
                            working_o <= result_reg;
                        end
                        if (kind_reg == K_ORF || kind_reg == K_MOVE_FILE_OP) begin
                            flag_n_o <= result_reg[7];
                            flag_z_o <= (result_reg == 8'h00);
                        end
                        if ((kind_reg == K_INCZ && result_reg == 8'h00) ||
                            (kind_reg == K_INCNZ && result_reg != 8'h00)) begin
                            skip_o <= 1'b1;
                            state_reg <= ST_SKIP;
                        end
                    end
                    K_ORL: begin
                        working_o <= result_reg;
                        flag_n_o <= result_reg[7];
                        flag_z_o <= (result_reg == 8'h00);
                    end
                    K_LOAD_LITERAL_OP: working_o <= first_reg[7:0];
                    K_LOAD_BANK_OP: bank_selector_register_o <= {4'h0, first_reg[3:0]};
                    K_STORE_WORKING_OP: begin
                        data_wr_o <= 1'b1;
                        data_wr_o_data <= result_reg;
                    end
                    K_POINTER_LOAD_OP: begin
                        pointer_sel_o <= first_reg[5:4];
                        data_pointer_o <= {first_reg[3:0], 8'h00};
                        data_pointer_high_wr_o <= 1'b1;
                        state_reg <= ST_SECOND;
                    end
                    K_FILE_TO_FILE_MOVE_OP: state_reg <= ST_SECOND;
                    default: state_reg <= ST_FIRST;
                    endcase
                end else if (state_reg == ST_SECOND) begin
                    state_reg <= ST_FIRST;
                    if (kind_reg == K_POINTER_LOAD_OP) begin
                        data_pointer_o <= {data_pointer_o[11:8], instr_word_i[7:0]};
                        data_pointer_low_wr_o <= 1'b1;
                    end else begin
                        // rely on software not targeting pc or stack
                        data_wr_o <= 1'b1;
                        data_wr_o_data <= result_reg;
                    end
                end else if (state_reg == ST_SKIP) begin
                    // discarded word shown during the skip cycle decides cost
                    state_reg <= two_word(instr_word_i) ? ST_SKIP2 : ST_FIRST;
                    skip_o <= two_word(instr_word_i);
                end else begin
                    state_reg <= ST_FIRST;
                    skip_o <= 1'b0;
                end
            end
            endcase
        end
    end
endmodule // move_or_increment_core

// file: verification/move_or_increment_monitor.sv
// port-level assertions for the move / or / increment execution core
`timescale 1ns/1ns
module move_or_increment_monitor (
    // clock and reset
    input wire mclk_i,
    input wire reset_n_i,
    // observed outputs
    input wire data_rd_o,
    input wire data_wr_o,
    input wire [7:0] bank_selector_register_o,
    input wire data_pointer_high_wr_o,
    input wire data_pointer_low_wr_o,
    input wire skip_o,
    input wire [1:0] phase_o,
    input wire advance_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_phase_step;
        (phase_o != 2'd0) |=> (phase_o == $past(phase_o) + 2'd1);
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase skipped a step");

    property p_advance;
        advance_o |=> !advance_o [*3] ##1 advance_o;
    endproperty
    a_advance: assert property (p_advance) else $error("cycle end pulse off");

    property p_rd_phase;
        data_rd_o |-> (phase_o == 2'd1);
    endproperty
    a_rd_phase: assert property (p_rd_phase) else $error("read outside its phase");

    property p_rd_once;
        data_rd_o |=> !data_rd_o [*3];
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("more than one read a cycle");

    property p_wr_phase;
        data_wr_o |-> (phase_o == 2'd3) && !data_rd_o;
    endproperty
    a_wr_phase: assert property (p_wr_phase) else $error("write outside its phase");

    property p_bank_high;
        bank_selector_register_o[7:4] == 4'h0;
    endproperty
    a_bank_high: assert property (p_bank_high) else $error("bank upper nibble set");

    property p_ptr_pair;
        data_pointer_high_wr_o |-> ##4 data_pointer_low_wr_o;
    endproperty
    a_ptr_pair: assert property (p_ptr_pair) else $error("pointer low half late");

    // discarded cycle must neither read nor write
    property p_skip_quiet;
        (skip_o && phase_o == 2'd1) |-> !data_rd_o ##2 !data_wr_o;
    endproperty
    a_skip_quiet: assert property (p_skip_quiet) else $error("discarded word acted");

    c_skip: cover property (skip_o && phase_o == 2'd1);
    c_write: cover property (data_wr_o);
    c_pointer: cover property (data_pointer_high_wr_o);
endmodule // move_or_increment_monitor

// file: verification/data_memory_model.sv
// data memory partner: 4096 bytes, read combinationally while strobed
`timescale 1ns/1ns
module data_memory_model (
    // clock
    input wire mclk_i,
    // access from the core
    input wire [11:0] data_addr_i,
    input wire data_rd_i,
    input wire data_wr_i,
    input wire [7:0] data_wr_data_i,
    // read data back to the core
    output wire [7:0] data_rd_data_o
);
    reg [7:0] mem [0:4095];
    reg [7:0] junk_reg = 8'h3C;

    // unselected bus shows a moving pattern, never a stale byte
    assign data_rd_data_o = data_rd_i ? mem[data_addr_i] : junk_reg;

    always @(posedge mclk_i) begin
        junk_reg <= ~junk_reg + 8'h01;
        if (data_wr_i) begin
            mem[data_addr_i] <= data_wr_data_i;
        end
    end
endmodule // data_memory_model

// file: verification/cpu_move_or_increment_ops_test.sv
// self-checking bench for the move / or / increment execution core
`timescale 1ns/1ns
`include "move_or_increment_regs.vh"
module cpu_move_or_increment_ops_test;
    localparam [7:0] LDL = `OP8_LOAD_LITERAL;
    localparam [7:0] ORL = `OP8_OR_LITERAL;
    localparam [7:0] LDB = `OP8_LOAD_BANK;
    localparam [6:0] STW = `OP7_STORE_WORKING;
    reg mclk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg extended_set_i = 1'b0;
    reg ext_mode = 1'b0;
    reg [15:0] instr_word_i = 16'h0000;
    reg skip_seen = 1'b0;
    reg [2:0] skips = 3'b000;
    integer miscompares = 0;
    integer num_checks = 0;
    wire [7:0] data_rd_i, working_o, bank_selector_register_o, data_wr_o_data;
    wire [11:0] data_addr_o, data_pointer_o;
    wire [8:0] pointer_index_o;
    wire [1:0] pointer_sel_o, phase_o;
    wire data_rd_o, data_wr_o, flag_n_o, flag_z_o, skip_o, advance_o;
    wire data_pointer_high_wr_o, data_pointer_low_wr_o;

    always #10 mclk_i = ~mclk_i;

    move_or_increment_core dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .extended_set_i(extended_set_i),
        .instr_word_i(instr_word_i), .data_rd_i(data_rd_i), .data_addr_o(data_addr_o),
        .data_rd_o(data_rd_o), .data_wr_o(data_wr_o), .data_wr_o_data(data_wr_o_data),
        .working_o(working_o), .bank_selector_register_o(bank_selector_register_o),
        .flag_n_o(flag_n_o), .flag_z_o(flag_z_o), .pointer_sel_o(pointer_sel_o),
        .data_pointer_o(data_pointer_o), .data_pointer_high_wr_o(data_pointer_high_wr_o),
        .data_pointer_low_wr_o(data_pointer_low_wr_o), .pointer_index_o(pointer_index_o),
        .skip_o(skip_o), .phase_o(phase_o), .advance_o(advance_o)
    );

    data_memory_model mem_model (
        .mclk_i(mclk_i), .data_addr_i(data_addr_o), .data_rd_i(data_rd_o),
        .data_wr_i(data_wr_o), .data_wr_data_i(data_wr_o_data), .data_rd_data_o(data_rd_i)
    );

    // ------------------------------------------------------------
    // drivers and comparison
    // ------------------------------------------------------------
    function [15:0] fw(input [5:0] op, input d, input a, input [7:0] f);
        fw = {op, d, a, f};
    endfunction

    // word set at the edge closing the previous cycle, so it stands all four phases
    task run(input [15:0] w);
        begin
            while (phase_o !== 2'd2) @(negedge mclk_i);
            @(posedge mclk_i);
            instr_word_i <= w;
            extended_set_i <= ext_mode;
            @(negedge mclk_i);
            while (phase_o !== 2'd2) begin
                if (phase_o === 2'd1) skip_seen = (skip_o === 1'b1);
                @(negedge mclk_i);
            end
        end
    endtask

    // results land one cycle later, so an idle word follows
    task ex(input [15:0] w);
        begin
            run(w);
            run(16'h0000);
        end
    endtask

    // one tally keeps the fail line in one shape for every kind
    task tally(input ok, input [11:0] got, input [11:0] exp);
        begin
            num_checks = num_checks + 1;
            if (!ok) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task chk_byte(input [7:0] got, input [7:0] exp);
        begin
            tally(got === exp, {4'h0, got}, {4'h0, exp});
        end
    endtask

    task chk_flags(input [1:0] got, input [1:0] exp);
        begin
            tally(got === exp, {10'h000, got}, {10'h000, exp});
        end
    endtask

    task chk_word(input [11:0] got, input [11:0] exp);
        begin
            tally(got === exp, got, exp);
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_literal;
        begin
            ex({LDL, 8'h9A});
            chk_byte(working_o, 8'h9A);
            ex({ORL, 8'h35});
            chk_byte(working_o, 8'hBF);
            chk_flags({flag_n_o, flag_z_o}, 2'b10);
            ex({LDL, 8'h00});
            chk_flags({flag_n_o, flag_z_o}, 2'b10);
            ex({ORL, 8'h00});
            chk_flags({flag_n_o, flag_z_o}, 2'b01);
        end
    endtask

    task t_store;
        begin
            ex({LDB, 8'hF3});
            chk_byte(bank_selector_register_o, 8'h03);
            ex({LDL, 8'h13});
            ex({STW, 1'b0, 8'h20});
            ex({STW, 1'b1, 8'h44});
            ex({STW, 1'b0, 8'h90});
            chk_byte(mem_model.mem[12'h020], 8'h13);
            chk_flags({flag_n_o, flag_z_o}, 2'b01);
            chk_byte(mem_model.mem[12'h344], 8'h13);
            chk_byte(mem_model.mem[12'hF90], 8'h13);
        end
    endtask

    task t_or_move;
        begin
            ex({LDL, 8'h91});
            ex(fw(`OP6_OR_FILE, 1'b0, 1'b0, 8'h20));
            chk_byte(working_o, 8'h93);
            chk_flags({flag_n_o, flag_z_o}, 2'b10);
            chk_byte(mem_model.mem[12'h020], 8'h13);
            ex(fw(`OP6_OR_FILE, 1'b1, 1'b0, 8'h20));
            chk_byte(mem_model.mem[12'h020], 8'h93);
            // zero flag set first so the move has to change both flags
            ex({LDL, 8'h00});
            ex({ORL, 8'h00});
            ex(fw(`OP6_MOVE_FILE, 1'b0, 1'b0, 8'h20));
            chk_byte(working_o, 8'h93);
            chk_flags({flag_n_o, flag_z_o}, 2'b10);
        end
    endtask

    task t_file_move;
        begin
            // flags opposite to the moved byte, so an update would show
            ex({LDL, 8'h00});
            ex({ORL, 8'h00});
            // destination kept clear of program counter and stack bytes
            run(16'hC020);
            ex(16'hFABC);
            chk_byte(mem_model.mem[12'hABC], 8'h93);
            chk_flags({flag_n_o, flag_z_o}, 2'b01);
        end
    endtask

    task t_skip;
        begin
            ex({LDL, 8'hFF});
            ex({STW, 1'b0, 8'h21});
            run(fw(`OP6_INC_SKIP_ZERO, 1'b1, 1'b0, 8'h21));
            run({LDL, 8'h77});
            skips[0] = skip_seen;
            run(fw(`OP6_INC_SKIP_ZERO, 1'b0, 1'b0, 8'h21));
            chk_byte(working_o, 8'hFF);
            run({LDL, 8'h66});
            skips[1] = skip_seen;
            run(16'h0000);
            chk_byte(mem_model.mem[12'h021], 8'h00);
            chk_flags({flag_n_o, flag_z_o}, 2'b01);
            chk_byte(working_o, 8'h66);
            chk_word({10'h000, skips[1:0]}, 12'h001);
            run(fw(`OP6_INC_SKIP_NONZERO, 1'b1, 1'b0, 8'h21));
            run(16'hC021);
            skips[0] = skip_seen;
            run(16'hFABC);
            skips[1] = skip_seen;
            run(16'h0000);
            skips[2] = skip_seen;
            chk_word({9'h000, skips}, 12'h003);
            chk_byte(mem_model.mem[12'hABC], 8'h93);
            ex({LDL, 8'hFF});
            ex({STW, 1'b0, 8'h21});
            run(fw(`OP6_INC_SKIP_NONZERO, 1'b1, 1'b0, 8'h21));
            ex({LDL, 8'h44});
            chk_byte(working_o, 8'h44);
            chk_byte(mem_model.mem[12'h021], 8'h00);
        end
    endtask

    task t_pointer;
        begin
            run(16'hEE23);
            ex(16'hF0AB);
            chk_word({10'h000, pointer_sel_o}, 12'h002);
            chk_word(data_pointer_o, 12'h3AB);
        end
    endtask

    task t_indexed;
        begin
            // index is looked at in the word's own cycle, before the next decode
            ext_mode = 1'b1;
            run({STW, 1'b0, 8'h5F});
            chk_word({3'h0, pointer_index_o}, 12'h15F);
            run({STW, 1'b0, 8'h60});
            chk_word({3'h0, pointer_index_o}, 12'h000);
            run({LDL, 8'h10});
            chk_word({3'h0, pointer_index_o}, 12'h000);
            ext_mode = 1'b0;
            run({STW, 1'b0, 8'h5F});
            chk_word({3'h0, pointer_index_o}, 12'h000);
            run(16'h0000);
        end
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_literal;
        t_store;
        t_or_move;
        t_file_move;
        t_skip;
        t_pointer;
        t_indexed;
        stop_test;
    end

    // whole run needs well under 20 us
    initial begin
        #100000;
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule // cpu_move_or_increment_ops_test

bind move_or_increment_core move_or_increment_monitor mon (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .data_rd_o(data_rd_o), .data_wr_o(data_wr_o),
    .bank_selector_register_o(bank_selector_register_o),
    .data_pointer_high_wr_o(data_pointer_high_wr_o),
    .data_pointer_low_wr_o(data_pointer_low_wr_o), .skip_o(skip_o), .phase_o(phase_o),
    .advance_o(advance_o)
);
